// File: design/hsc_pkg.sv
package hsc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HSC_OFS_SET_A   = 8'h90;
  localparam logic [7:0] HSC_OFS_SET_B   = 8'h91;
  localparam logic [7:0] HSC_OFS_COMP_LO = 8'h92;
  localparam logic [7:0] HSC_OFS_MULT    = 8'h93;
  localparam logic [7:0] HSC_OFS_UI      = 8'ha0;
  localparam logic [7:0] HSC_OFS_PROX    = 8'ha1;
  localparam logic [7:0] HSC_OFS_TOUCH   = 8'ha2;

  // ----------------------------------------------------------------
  // reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] HSC_RST_SET_A   = 8'h03;
  localparam logic [7:0] HSC_RST_SET_B   = 8'h50;
  localparam logic [7:0] HSC_RST_COMP_LO = 8'h00;
  localparam logic [7:0] HSC_RST_MULT    = 8'h00;
  localparam logic [7:0] HSC_RST_UI      = 8'h00;
  localparam logic [7:0] HSC_RST_PROX    = 8'h19;
  localparam logic [7:0] HSC_RST_TOUCH   = 8'h19;
  localparam logic [7:0] HSC_MSK_SET_A   = 8'h33;
  localparam logic [7:0] HSC_MSK_UI      = 8'h77;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HSC_DIV_LSB    = 4;
  localparam int HSC_MODE_LSB   = 0;
  localparam int HSC_BASE_LSB   = 6;
  localparam int HSC_TGT_LSB    = 0;
  localparam int HSC_CHI_LSB    = 6;
  localparam int HSC_COARSE_LSB = 4;
  localparam int HSC_FINE_LSB   = 0;
  localparam int HSC_LIN_BIT    = 6;
  localparam int HSC_THYS_LSB   = 4;
  localparam int HSC_SWAP_BIT   = 2;
  localparam int HSC_PHYS_LSB   = 0;

  // ----------------------------------------------------------------
  // decoded values
  // ----------------------------------------------------------------
  localparam logic [4:0] HSC_DIV_2    = 5'h02;
  localparam logic [4:0] HSC_DIV_8    = 5'h08;
  localparam logic [4:0] HSC_DIV_16   = 5'h10;
  localparam logic [7:0] HSC_BASE_75  = 8'h4b;
  localparam logic [7:0] HSC_BASE_150 = 8'h96;
  localparam logic [7:0] HSC_BASE_200 = 8'hc8;
  localparam logic [1:0] HSC_TUNE_OFF     = 2'h0;
  localparam logic [1:0] HSC_TUNE_PARTIAL = 2'h1;
  localparam logic [1:0] HSC_TUNE_SEMI    = 2'h2;
  localparam logic [1:0] HSC_TUNE_FULL    = 2'h3;

  typedef struct packed {
    logic [4:0]  transfer_rate_divider;
    logic [1:0]  auto_tune_mode;
    logic        coarse_tune_en;
    logic        fine_tune_en;
    logic [7:0]  auto_tune_base;
    logic [10:0] auto_tune_target;
    logic [9:0]  comp;
    logic [1:0]  coarse;
    logic [3:0]  fine;
    logic        lin_en;
    logic        swap_dir;
    logic [7:0]  prox_thr;
    logic [7:0]  prox_hyst;
    logic [9:0]  touch_thr;
    logic [9:0]  touch_hyst;
  } hsc_cfg_t;

  typedef struct packed {
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] comp_lo;
    logic [7:0] mult;
    logic [7:0] ui;
    logic [7:0] prox;
    logic [7:0] touch;
    logic [7:0] rdata;
    hsc_cfg_t   cfg;
  } hsc_state_t;

endpackage

// File: design/hsc_config_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - divider bits 5-4: 00 -> /2, 01 -> /8, 11 -> /16
// - tuning mode bits 1-0: off, partial, semi-partial, full
// - tuning base bits 7-6: 00 -> 75, 01 -> 150, 11 -> 200
// - tuning target is the six-bit field times 32
// - 10-bit compensation: low byte at 0x92, top two bits at 0x93[7:6]
// - coarse multiplier in bits 5-4, fine multiplier in bits 3-0
// - bit 6 of switch settings enables output linearisation
// - touch hysteresis: 00 off, 01 one eighth, 11 one sixteenth
// - bit 2 of switch settings swaps field direction indication
// - prox hysteresis: 00 off, 01 or 10 one eighth, 11 one sixteenth
// - prox threshold is the register value, reset 25
// - touch threshold is four times the register value
module hsc_config_regs
  import hsc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output hsc_cfg_t        cfg_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hsc_state_t s_r;
  hsc_state_t s_nxt;

  function automatic hsc_cfg_t decode(input hsc_state_t s);
    hsc_cfg_t c;
    c = '0;
    unique case (s.set_a[HSC_DIV_LSB +: 2])
      2'b00:   c.transfer_rate_divider = HSC_DIV_2;
      2'b01:   c.transfer_rate_divider = HSC_DIV_8;
      default: c.transfer_rate_divider = HSC_DIV_16;
    endcase
    c.auto_tune_mode = s.set_a[HSC_MODE_LSB +: 2];
    c.coarse_tune_en = (c.auto_tune_mode == HSC_TUNE_FULL);
    c.fine_tune_en   = (c.auto_tune_mode != HSC_TUNE_OFF) &&
                       (c.auto_tune_mode != HSC_TUNE_PARTIAL);
    unique case (s.set_b[HSC_BASE_LSB +: 2])
      2'b00:   c.auto_tune_base = HSC_BASE_75;
      2'b01:   c.auto_tune_base = HSC_BASE_150;
      default: c.auto_tune_base = HSC_BASE_200;
    endcase
    c.auto_tune_target = {s.set_b[HSC_TGT_LSB +: 6], 5'h00};
    c.comp     = {s.mult[HSC_CHI_LSB +: 2], s.comp_lo};
    c.coarse   = s.mult[HSC_COARSE_LSB +: 2];
    c.fine     = s.mult[HSC_FINE_LSB +: 4];
    c.lin_en   = s.ui[HSC_LIN_BIT];
    c.swap_dir = s.ui[HSC_SWAP_BIT];
    c.prox_thr  = s.prox;
    c.touch_thr = {s.touch, 2'b00};
    unique case (s.ui[HSC_THYS_LSB +: 2])
      2'b00:   c.touch_hyst = 10'h000;
      2'b11:   c.touch_hyst = {4'h0, c.touch_thr[9:4]};
      default: c.touch_hyst = {3'h0, c.touch_thr[9:3]};
    endcase
    unique case (s.ui[HSC_PHYS_LSB +: 2])
      2'b00:   c.prox_hyst = 8'h00;
      2'b11:   c.prox_hyst = {4'h0, c.prox_thr[7:4]};
      default: c.prox_hyst = {3'h0, c.prox_thr[7:3]};
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        HSC_OFS_SET_A:   s_nxt.set_a   = reg_wdata_i & HSC_MSK_SET_A;
        HSC_OFS_SET_B:   s_nxt.set_b   = reg_wdata_i;
        HSC_OFS_COMP_LO: s_nxt.comp_lo = reg_wdata_i;
        HSC_OFS_MULT:    s_nxt.mult    = reg_wdata_i;
        HSC_OFS_UI:      s_nxt.ui      = reg_wdata_i & HSC_MSK_UI;
        HSC_OFS_PROX:    s_nxt.prox    = reg_wdata_i;
        HSC_OFS_TOUCH:   s_nxt.touch   = reg_wdata_i;
        default:         s_nxt.set_b   = s_r.set_b;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        HSC_OFS_SET_A:   s_nxt.rdata = s_r.set_a;
        HSC_OFS_SET_B:   s_nxt.rdata = s_r.set_b;
        HSC_OFS_COMP_LO: s_nxt.rdata = s_r.comp_lo;
        HSC_OFS_MULT:    s_nxt.rdata = s_r.mult;
        HSC_OFS_UI:      s_nxt.rdata = s_r.ui;
        HSC_OFS_PROX:    s_nxt.rdata = s_r.prox;
        HSC_OFS_TOUCH:   s_nxt.rdata = s_r.touch;
        default:         s_nxt.rdata = 8'h00;
      endcase
    end
    // synchronous reset overrides any request in the same cycle
    if (!rst_n_i) begin
      s_nxt         = '0;
      s_nxt.set_a   = HSC_RST_SET_A;
      s_nxt.set_b   = HSC_RST_SET_B;
      s_nxt.comp_lo = HSC_RST_COMP_LO;
      s_nxt.mult    = HSC_RST_MULT;
      s_nxt.ui      = HSC_RST_UI;
      s_nxt.prox    = HSC_RST_PROX;
      s_nxt.touch   = HSC_RST_TOUCH;
    end
    s_nxt.cfg = decode(s_nxt);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign reg_rdata_o = s_r.rdata;
  assign cfg_o       = s_r.cfg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic wr_a, wr_b, wr_m, wr_u, wr_t, wr_p;
  logic wr_c, wr_x, rd_x, map_hit;
  assign wr_a = reg_wr_i && reg_addr_i == HSC_OFS_SET_A;
  assign wr_b = reg_wr_i && reg_addr_i == HSC_OFS_SET_B;
  assign wr_m = reg_wr_i && reg_addr_i == HSC_OFS_MULT;
  assign wr_u = reg_wr_i && reg_addr_i == HSC_OFS_UI;
  assign wr_t = reg_wr_i && reg_addr_i == HSC_OFS_TOUCH;
  assign wr_p = reg_wr_i && reg_addr_i == HSC_OFS_PROX;
  assign wr_c    = reg_wr_i && reg_addr_i == HSC_OFS_COMP_LO;
  assign map_hit = reg_addr_i inside {HSC_OFS_SET_A, HSC_OFS_SET_B, HSC_OFS_COMP_LO, HSC_OFS_MULT,
                                      HSC_OFS_UI, HSC_OFS_PROX, HSC_OFS_TOUCH};
  assign wr_x    = reg_wr_i && !map_hit;
  assign rd_x    = reg_rd_i && !map_hit;

  AST_DIV8: assert property (wr_a && reg_wdata_i[5:4] == 2'b01 |=>
    cfg_o.transfer_rate_divider == 5'h08) else $error("divider not 8");
  AST_MODE: assert property (wr_a && reg_wdata_i[1:0] == 2'b01 |=>
    !cfg_o.coarse_tune_en && !cfg_o.fine_tune_en) else $error("partial mode wrong");
  AST_BASE: assert property (wr_b && reg_wdata_i[7:6] == 2'b11 |=>
    cfg_o.auto_tune_base == 8'hc8) else $error("base not 200");
  AST_TGT: assert property (wr_b |=>
    cfg_o.auto_tune_target == 11'($past(reg_wdata_i[5:0]) * 32)) else $error("target wrong");
  AST_COMP: assert property (wr_m && !reg_rd_i |=>
    cfg_o.comp[9:8] == $past(reg_wdata_i[7:6]) && cfg_o.fine == $past(reg_wdata_i[3:0]))
    else $error("compensation top bits wrong");
  AST_LIN: assert property (wr_u |=> cfg_o.lin_en == $past(reg_wdata_i[6])
    && cfg_o.swap_dir == $past(reg_wdata_i[2])) else $error("ui bits wrong");
  AST_THYS: assert property (cfg_o.touch_hyst ==
    (s_r.ui[5:4] == 2'b00 ? 10'h000 : s_r.ui[5:4] == 2'b11 ? cfg_o.touch_thr / 16
     : cfg_o.touch_thr / 8)) else $error("touch hysteresis wrong");
  AST_PHYS: assert property (wr_u && reg_wdata_i[1:0] == 2'b10 && !wr_p |=>
    cfg_o.prox_hyst == cfg_o.prox_thr / 8) else $error("prox hysteresis wrong");
  AST_PROX: assert property (wr_p |=> cfg_o.prox_thr == $past(reg_wdata_i))
    else $error("prox threshold wrong");
  AST_TOUCH: assert property (wr_t |=> ##1 cfg_o.touch_thr ==
    10'($past(reg_wdata_i, 2)) * 10'h004 || $past(wr_t)) else $error("touch threshold wrong");
  AST_RSVD: assert property (reg_rd_i && reg_addr_i == HSC_OFS_UI |=>
    reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0) else $error("reserved bit read one");

  // ----------------------------------------------------------------
  // decode checks
  // ----------------------------------------------------------------
  AST_DIV2: assert property (wr_a && reg_wdata_i[5:4] == 2'b00 |=>
    cfg_o.transfer_rate_divider == 5'h02) else $error("divider not 2");
  AST_DIV16: assert property (wr_a && reg_wdata_i[5:4] == 2'b11 |=>
    cfg_o.transfer_rate_divider == 5'h10) else $error("divider not 16");
  AST_OFF: assert property (wr_a && reg_wdata_i[1:0] == 2'b00 |=>
    cfg_o.auto_tune_mode == 2'b00 && !cfg_o.coarse_tune_en && !cfg_o.fine_tune_en)
    else $error("tuning not off");
  AST_SEMI: assert property (wr_a && reg_wdata_i[1:0] == 2'b10 |=>
    !cfg_o.coarse_tune_en && cfg_o.fine_tune_en) else $error("semi-partial mode wrong");
  AST_FULL: assert property (wr_a && reg_wdata_i[1:0] == 2'b11 |=>
    cfg_o.coarse_tune_en && cfg_o.fine_tune_en) else $error("full mode wrong");
  AST_BASE75: assert property (wr_b && reg_wdata_i[7:6] == 2'b00 |=>
    cfg_o.auto_tune_base == 8'h4b) else $error("base not 75");
  AST_BASE150: assert property (wr_b && reg_wdata_i[7:6] == 2'b01 |=>
    cfg_o.auto_tune_base == 8'h96) else $error("base not 150");
  AST_TGT0: assert property (wr_b && reg_wdata_i[5:0] == 6'h00 |=>
    cfg_o.auto_tune_target == 11'h000) else $error("target not zero");
  AST_COMPLO: assert property (wr_c |=> cfg_o.comp[7:0] == $past(reg_wdata_i))
    else $error("compensation low byte wrong");
  AST_COMP_KEEP: assert property (wr_c |=> $stable(cfg_o.comp[9:8]))
    else $error("compensation top bits moved");
  AST_MULT_KEEP: assert property (wr_m |=> $stable(cfg_o.comp[7:0]))
    else $error("compensation low byte moved");
  AST_COARSE: assert property (wr_m |=> cfg_o.coarse == $past(reg_wdata_i[5:4]))
    else $error("coarse multiplier wrong");
  AST_DIR0: assert property (wr_u && !reg_wdata_i[2] |=> !cfg_o.swap_dir)
    else $error("direction swapped");
  AST_PHYS_ALL: assert property (cfg_o.prox_hyst ==
    (s_r.ui[1:0] == 2'b00 ? 8'h00 : s_r.ui[1:0] == 2'b11 ? cfg_o.prox_thr / 16
     : cfg_o.prox_thr / 8)) else $error("prox hysteresis level wrong");
  AST_RSVD_A: assert property (reg_rd_i && reg_addr_i == HSC_OFS_SET_A |=>
    reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[3:2] == 2'b00)
    else $error("reserved settings bits read one");
  AST_RDOLD: assert property (reg_rd_i && wr_p |=>
    reg_rdata_o == $past(cfg_o.prox_thr)) else $error("read during write not old value");

  // ----------------------------------------------------------------
  // map and reset checks
  // ----------------------------------------------------------------
  AST_UNMAP_RD: assert property (rd_x |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_UNMAP_WR: assert property (wr_x |=> $stable(cfg_o))
    else $error("unmapped write changed settings");
  AST_RST: assert property (disable iff (1'b0) !rst_n_i |=> reg_rdata_o == 8'h00 &&
    cfg_o.prox_thr == 8'h19 && cfg_o.touch_thr == 10'h064) else $error("reset values wrong");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  COV_FULL: cover property (wr_a ##1 cfg_o.auto_tune_mode == HSC_TUNE_FULL);
  COV_SEMI: cover property (wr_a && reg_wdata_i[1:0] == 2'b10);
  COV_UNMAP: cover property (rd_x ##1 reg_rdata_o == 8'h00);
  COV_RD: cover property (reg_rd_i && reg_addr_i == HSC_OFS_PROX ##1 reg_rdata_o == 8'h19);
  COV_HYS: cover property (wr_u && reg_wdata_i[5:4] == 2'b11);

endmodule // hsc_config_regs

// File: test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import hsc_pkg::*;

  logic       clk_i;
  logic       rst_n_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  hsc_cfg_t   cfg_o;
  int         failures;
  int         cmp_count;
  int         cyc;

  hsc_config_regs dut (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .cfg_o       (cfg_o)
  );

  // ----------------------------------------
  // clock, watchdog, shared tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
    @(negedge clk_i);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    logic [7:0] ofs [7] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'ha0, 8'ha1, 8'ha2};
    logic [7:0] rv [7] = '{8'h03, 8'h50, 8'h00, 8'h00, 8'h00, 8'h19, 8'h19};
    chk(cfg_o.transfer_rate_divider, 11'd2);
    chk(cfg_o.auto_tune_mode, 11'd3);
    chk(cfg_o.auto_tune_base, 11'd150);
    chk(cfg_o.auto_tune_target, 11'd512);
    chk(cfg_o.prox_thr, 11'd25);
    chk(cfg_o.touch_thr, 11'd100);
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], v);
      chk(v, rv[i]);
    end
  endtask

  task automatic t_set_a();
    logic [7:0] v;
    logic [1:0] d;
    logic [1:0] m;
    logic [4:0] dv [4] = '{5'd2, 5'd8, 5'd16, 5'd16};
    logic [1:0] en [4] = '{2'b00, 2'b00, 2'b01, 2'b11};
    for (int i = 0; i < 4; i++) begin
      d = 2'(i);
      m = 2'(3 - i);
      wr(8'h90, {2'b11, d, 2'b11, m});
      chk(cfg_o.transfer_rate_divider, dv[i]);
      chk(cfg_o.auto_tune_mode, m);
      chk({cfg_o.coarse_tune_en, cfg_o.fine_tune_en}, en[m]);
      rd(8'h90, v);
      chk(v, {2'b00, d, 2'b00, m});
    end
  endtask

  task automatic t_set_b();
    logic [7:0] v;
    logic [5:0] f;
    logic [7:0] bs [4] = '{8'd75, 8'd150, 8'd200, 8'd200};
    for (int i = 0; i < 4; i++) begin
      f = 6'(i * 21);
      wr(8'h91, {2'(i), f});
      chk(cfg_o.auto_tune_base, bs[i]);
      chk(cfg_o.auto_tune_target, {f, 5'b0});
      rd(8'h91, v);
      chk(v, {2'(i), f});
    end
  endtask

  task automatic t_comp();
    logic [7:0] v;
    wr(8'h92, 8'ha5);
    wr(8'h93, 8'h9c);
    chk(cfg_o.comp, 11'h2a5);
    chk(cfg_o.coarse, 11'd1);
    chk(cfg_o.fine, 11'hc);
    wr(8'h92, 8'h3c);
    chk(cfg_o.comp, 11'h23c);
    wr(8'h93, 8'h7f);
    chk(cfg_o.comp, 11'h13c);
    chk({cfg_o.coarse, cfg_o.fine}, 11'h3f);
    rd(8'h93, v);
    chk(v, 8'h7f);
  endtask

  task automatic t_ui();
    logic [7:0] v;
    logic [1:0] k;
    logic [7:0] ph [4] = '{8'd0, 8'd25, 8'd25, 8'd12};
    logic [9:0] th [4] = '{10'd0, 10'd127, 10'd127, 10'd63};
    wr(8'ha1, 8'hc8);
    wr(8'ha2, 8'hff);
    chk(cfg_o.prox_thr, 11'd200);
    chk(cfg_o.touch_thr, 11'd1020);
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wr(8'ha0, {1'b1, k[0], k, 1'b1, k[1], k});
      chk(cfg_o.lin_en, k[0]);
      chk(cfg_o.swap_dir, k[1]);
      chk(cfg_o.touch_hyst, th[i]);
      chk(cfg_o.prox_hyst, ph[i]);
      rd(8'ha0, v);
      chk(v, {1'b0, k[0], k, 1'b0, k[1], k});
    end
  endtask

  task automatic t_misc();
    logic [7:0] v;
    wr(8'h94, 8'hff);
    rd(8'h94, v);
    chk(v, 8'h00);
    chk(cfg_o.prox_thr, 11'd200);
    reg_addr_i = 8'ha1;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b1;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, 8'hc8);
    chk(cfg_o.prox_thr, 11'd0);
    reg_addr_i = 8'ha2;
    reg_wdata_i = 8'h01;
    @(negedge clk_i);
    reg_addr_i = 8'ha1;
    reg_wdata_i = 8'hff;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    chk(cfg_o.touch_thr, 11'd4);
    chk(cfg_o.prox_thr, 11'd255);
  endtask

  task automatic t_rst2();
    logic [7:0] v;
    @(negedge clk_i);
    wr(8'h90, 8'h10);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(cfg_o.transfer_rate_divider, 11'd2);
    chk(cfg_o.auto_tune_mode, 11'd3);
    chk(cfg_o.prox_thr, 11'd25);
    chk(cfg_o.touch_thr, 11'd100);
    chk(reg_rdata_o, 11'h000);
    wr(8'ha1, 8'h40);
    chk(cfg_o.prox_thr, 11'h040);
    rd(8'h90, v);
    chk(v, 8'h03);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_set_a();
    t_set_b();
    t_comp();
    t_ui();
    t_misc();
    t_rst2();
    stop_test();
  end

endmodule // tb_top
